// file: pkg/smio_pkg.sv
// Constants of the servo motion I/O block.
package smio_pkg;

    // Clock rates in MHz and the sample period in ns.
    localparam int CLK_MHZ = 100;
    localparam int CORE_MHZ = 40;
    localparam int SAMPLE_NS = 25;

    // Fractional core tick generator.
    localparam int TICK_ACC_W = 7;
    localparam logic [TICK_ACC_W-1:0] TICK_STEP = 7'(CORE_MHZ);
    localparam logic [TICK_ACC_W-1:0] TICK_WRAP = 7'(CLK_MHZ);

    // Input filter length in samples.
    localparam int FILT_NS = 175;
    localparam int FILT_SAMPLES = FILT_NS / SAMPLE_NS;
    localparam logic [2:0] FILT_LAST = 3'(FILT_SAMPLES - 1);

    // Channel counts and widths.
    localparam int N_CH = 4;
    localparam int N_DED_OUT = 10;
    localparam int N_OUT = 18;
    localparam int N_DED_IN = 8;
    localparam int N_IN = 20;
    localparam int CNT_W = 14;
    localparam int DUTY_W = 12;

    // Modulator period and full scale.
    localparam int PWM_PERIOD = 2047;
    localparam logic [10:0] PWM_LAST = 11'(PWM_PERIOD - 1);
    localparam logic [11:0] PWM_FULL = 12'(PWM_PERIOD);
    localparam logic [11:0] PDM_WRAP = 12'(PWM_PERIOD);

    // Watchdog time.
    localparam int WDOG_TIME_US = 6500;
    localparam int WDOG_CYCLES = WDOG_TIME_US * CLK_MHZ;
    localparam int WDOG_W = 24;

    // Register byte addresses.
    localparam logic [3:0] REGION_CNT = 4'h0;
    localparam logic [3:0] REGION_PWM = 4'h1;
    localparam logic [7:0] A_DOUT = 8'h20;
    localparam logic [7:0] A_DINV = 8'h24;
    localparam logic [7:0] A_DIN = 8'h28;
    localparam logic [7:0] A_CTRL = 8'h2c;

    // Field positions.
    localparam int CNT_ARM_BIT = 14;
    localparam int PWM_DIR_BIT = 12;
    localparam int PWM_PDM_BIT = 13;
    localparam int CTRL_WDEN_BIT = 0;
    localparam int CTRL_TRIP_BIT = 1;
    localparam int SHARED_LSB = 10;
    localparam int DIN_Z_LSB = 8;
    localparam int DIN_A_LSB = 12;
    localparam int DIN_B_LSB = 16;

    // Encoder pin order in a channel.
    localparam int PH_A = 0;
    localparam int PH_B = 1;
    localparam int PH_Z = 2;

endpackage

// file: src/smio_qdec.sv
// One quadrature channel: synchroniser, filter, 4x counter, index clear.
module smio_qdec
    import smio_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    // Encoder pins.
    input wire logic encoder_phase_a_in_i,
    input wire logic encoder_phase_b_in_i,
    input wire logic encoder_index_in_i,
    // Control and results.
    input wire logic arm_i,
    output logic [CNT_W-1:0] count_o,
    output logic armed_o,
    output logic [2:0] level_o
);

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] lvl;
        logic [2:0] filt;
        logic [2:0][2:0] fcnt;
        logic [CNT_W-1:0] count;
        logic armed;
    } smio_qdec_s;

    smio_qdec_s s;
    smio_qdec_s next_s;

    // Synchronise, filter, count and handle the index.
    always_comb begin
        next_s = s;
        next_s.s1 = {encoder_index_in_i, encoder_phase_b_in_i, encoder_phase_a_in_i};
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < 3; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.lvl[i] = s.s3[i];
            end
        end
        // One sample per core tick; a new level must persist seven samples.
        if (tick_i) begin // R06 R08
            for (int i = 0; i < 3; i++) begin
                if (s.lvl[i] != s.filt[i]) begin
                    if (s.fcnt[i] == FILT_LAST) begin // R07
                        next_s.filt[i] = s.lvl[i];
                        next_s.fcnt[i] = 3'h0;
                    end else begin
                        next_s.fcnt[i] = s.fcnt[i] + 3'h1;
                    end
                end else begin
                    next_s.fcnt[i] = 3'h0;
                end
            end
        end
        // Every single edge of A or B moves the count; a double change is dropped.
        if ((next_s.filt[PH_A] ^ s.filt[PH_A]) ^ (next_s.filt[PH_B] ^ s.filt[PH_B])) begin // R09
            if (s.filt[PH_A] == next_s.filt[PH_B]) begin
                next_s.count = s.count + 14'h1;
            end else begin
                next_s.count = s.count - 14'h1;
            end
        end
        // A rising index edge clears the count once when armed.
        if (next_s.filt[PH_Z] && !s.filt[PH_Z] && s.armed) begin // R05 R23
            next_s.count = 14'h0;
            next_s.armed = 1'b0;
        end
        // A new arming request wins over a clear in the same cycle.
        if (arm_i) begin
            next_s.armed = 1'b1;
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign count_o = s.count;
    assign armed_o = s.armed;
    assign level_o = s.lvl; // R20
endmodule

// file: src/smio_pwm.sv
// One modulator channel: PWM or PDM, up/down or pwm+direction.
module smio_pwm
    import smio_pkg::*;
(
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic tick_i,
    // Settings.
    input wire logic [DUTY_W-1:0] duty_i,
    input wire logic pwmdir_i,
    input wire logic pdm_i,
    // Waveforms.
    output logic first_o,
    output logic second_o
);

    typedef struct packed {
        logic [10:0] cnt;
        logic [11:0] acc;
        logic first;
        logic second;
    } smio_pwm_s;

    smio_pwm_s s;
    smio_pwm_s next_s;
    logic neg;
    logic [11:0] mag;
    logic [11:0] sum;
    logic on;

    // Signed duty to magnitude, clamped to full scale so -2048 acts as -2047.
    always_comb begin
        neg = duty_i[DUTY_W-1];
        mag = neg ? 12'(-duty_i) : duty_i;
        if (mag > PWM_FULL) begin // R11
            mag = PWM_FULL;
        end
    end

    // Advance the period counter and, in PDM mode, the accumulator on each core tick.
    always_comb begin
        next_s = s;
        sum = s.acc + mag;
        on = 1'b0;
        if (tick_i) begin
            next_s.cnt = (s.cnt == PWM_LAST) ? 11'h0 : s.cnt + 11'h1; // R12
            if (pdm_i) begin // R13
                if (sum >= PDM_WRAP) begin
                    next_s.acc = sum - PDM_WRAP;
                    on = 1'b1;
                end else begin
                    next_s.acc = sum;
                end
            end else begin
                next_s.acc = 12'h0;
                on = {1'b0, s.cnt} < mag;
            end
            if (pwmdir_i) begin // R17
                next_s.first = on;
                next_s.second = neg; // R03
            end else begin
                next_s.first = on && !neg; // R18
                next_s.second = on && neg; // R19
            end
        end
    end

    // State register.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign first_o = s.first;
    assign second_o = s.second;
endmodule

// file: src/smio_top.sv
// Servo motion I/O block top.
//
// Contract
// R01 - Default-on watchdog tristates all outputs when host access stops.
// R02 - Watchdog trips about 6.5 ms after the last access.
// R03 - Pwm+direction: direction high for negative, low otherwise.
// R04 - Output polarity flip inverts the direction pin.
// R05 - Index acts on its rising edge.
// R06 - Encoder inputs sampled once per 25 ns core cycle.
// R07 - Filter rejects pulses shorter than seven samples.
// R08 - Four quadrature channels sample at 40 MHz.
// R09 - 4x counting on every A and B edge.
// R10 - Count change between host reads stays within 8191.
// R11 - 4095 duty settings from minus to plus full scale.
// R12 - PWM period is 2047 core cycles.
// R13 - Modulators also offer a PDM-like mode.
// R14 - Eighteen outputs: ten dedicated, eight shared.
// R15 - Twenty inputs: eight dedicated, twelve on encoder pins.
// R16 - Shared pin is modulator signal XOR its output bit.
// R17 - Pwm+direction: first pin PWM, second pin direction.
// R18 - First pin idle when command always negative.
// R19 - Second pin idle when command never negative.
// R20 - Encoder A and B pins also read as inputs.
// R21 - Host talks over EPP only.
// R22 - Status LED is channel 0 first XOR second.
// R23 - Armed index clears count once and reports it.
// R24 - All twenty inputs captured in one event.
// R25 - Dedicated outputs update together; shared with their modulator.
// R26 - Host reads and writes in a fixed sequence each period.
//
// The register addresses and the Wishbone register port were decided locally.
module smio_top
    import smio_pkg::*;
#(
    parameter int WDOG_LIMIT = WDOG_CYCLES
) (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Encoder and dedicated input pins.
    input wire logic [N_CH-1:0] encoder_phase_a_in_i,
    input wire logic [N_CH-1:0] encoder_phase_b_in_i,
    input wire logic [N_CH-1:0] encoder_index_in_i,
    input wire logic [N_DED_IN-1:0] dedicated_input_bit_i,
    // Output pins; pin_oe_o high while the pins are driven.
    output logic [N_DED_OUT-1:0] dedicated_output_bit_o,
    output logic [N_CH-1:0] modulated_out_first_o,
    output logic [N_CH-1:0] modulated_out_second_o,
    output logic status_led_o,
    output logic pin_oe_o
);

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic [TICK_ACC_W-1:0] tick_acc;
        logic tick;
        logic [WDOG_W-1:0] wd_cnt;
        logic wd_en;
        logic tripped;
        logic [N_OUT-1:0] dout;
        logic [N_OUT-1:0] output_polarity_flip;
        logic [N_DED_OUT-1:0] ded_act;
        logic [2*N_CH-1:0] shared_act;
        logic [N_CH-1:0][DUTY_W-1:0] duty;
        logic [N_CH-1:0] pwmdir;
        logic [N_CH-1:0] pdm;
        logic [N_CH-1:0] arm;
        logic [N_DED_IN-1:0] s1;
        logic [N_DED_IN-1:0] s2;
        logic [N_DED_IN-1:0] s3;
        logic [N_DED_IN-1:0] lvl;
        logic [N_DED_OUT-1:0] pin_ded;
        logic [N_CH-1:0] pin_first;
        logic [N_CH-1:0] pin_second;
        logic led;
        logic oe;
    } smio_top_s;

    smio_top_s s;
    smio_top_s next_s;

    logic [N_CH-1:0][CNT_W-1:0] count;
    logic [N_CH-1:0] armed;
    logic [N_CH-1:0][2:0] enc_lvl;
    logic [N_CH-1:0] pwm_first;
    logic [N_CH-1:0] pwm_second;
    logic req;
    logic [1:0] ch;
    logic [3:0] region;
    logic [N_IN-1:0] din;
    logic [31:0] cur;
    logic [31:0] wval;
    logic [TICK_ACC_W-1:0] acc_sum;

    // Byte-lane merge of a Wishbone write onto the current register value.
    function automatic logic [31:0] wb_merge(input logic [31:0] old_v, input logic [31:0] new_v, input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return r;
    endfunction

    // Channel blocks.
    for (genvar g = 0; g < N_CH; g++) begin : g_ch
        smio_qdec u_qdec (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .tick_i(s.tick),
            .encoder_phase_a_in_i(encoder_phase_a_in_i[g]),
            .encoder_phase_b_in_i(encoder_phase_b_in_i[g]),
            .encoder_index_in_i(encoder_index_in_i[g]),
            .arm_i(s.arm[g]),
            .count_o(count[g]),
            .armed_o(armed[g]),
            .level_o(enc_lvl[g])
        );
        smio_pwm u_pwm (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .ce_i(ce_i),
            .tick_i(s.tick),
            .duty_i(s.duty[g]),
            .pwmdir_i(s.pwmdir[g]),
            .pdm_i(s.pdm[g]),
            .first_o(pwm_first[g]),
            .second_o(pwm_second[g])
        );
    end

    // Bus decode and the live view of all twenty inputs.
    always_comb begin
        req = wb_cyc_i && wb_stb_i && !s.ack;
        ch = wb_adr_i[3:2];
        region = wb_adr_i[7:4];
        din = '0;
        din[N_DED_IN-1:0] = s.lvl;
        for (int i = 0; i < N_CH; i++) begin // R15 R20
            din[DIN_Z_LSB + i] = enc_lvl[i][PH_Z];
            din[DIN_A_LSB + i] = enc_lvl[i][PH_A];
            din[DIN_B_LSB + i] = enc_lvl[i][PH_B];
        end
        cur = 32'h0;
        if (region == REGION_CNT) begin
            cur[CNT_W-1:0] = count[ch];
            cur[CNT_ARM_BIT] = armed[ch];
        end else if (region == REGION_PWM) begin
            cur[DUTY_W-1:0] = s.duty[ch];
            cur[PWM_DIR_BIT] = s.pwmdir[ch];
            cur[PWM_PDM_BIT] = s.pdm[ch];
        end else if (wb_adr_i == A_DOUT) begin
            cur[N_OUT-1:0] = s.dout;
        end else if (wb_adr_i == A_DINV) begin
            cur[N_OUT-1:0] = s.output_polarity_flip;
        end else if (wb_adr_i == A_DIN) begin
            cur[N_IN-1:0] = din;
        end else if (wb_adr_i == A_CTRL) begin
            cur[CTRL_WDEN_BIT] = s.wd_en;
            cur[CTRL_TRIP_BIT] = s.tripped;
        end
        wval = wb_merge(cur, wb_dat_i, wb_sel_i);
    end

    // Next state of the block.
    always_comb begin
        next_s = s;
        next_s.arm = '0;
        next_s.s1 = dedicated_input_bit_i;
        next_s.s2 = s.s1;
        next_s.s3 = s.s2;
        for (int i = 0; i < N_DED_IN; i++) begin
            if (s.s2[i] == s.s3[i]) begin
                next_s.lvl[i] = s.s3[i];
            end
        end
        // Core tick at the core rate from the faster bus clock.
        acc_sum = s.tick_acc + TICK_STEP;
        if (acc_sum >= TICK_WRAP) begin // R06 R08
            next_s.tick_acc = acc_sum - TICK_WRAP;
            next_s.tick = 1'b1;
        end else begin
            next_s.tick_acc = acc_sum;
            next_s.tick = 1'b0;
        end
        // Single-cycle ack one clock after the request; only reads load the data.
        next_s.ack = req;
        if (req && !wb_we_i) begin
            next_s.rdata = cur; // R24
        end
        if (req && wb_we_i) begin
            if (region == REGION_CNT) begin
                next_s.arm[ch] = wval[CNT_ARM_BIT]; // R23
            end else if (region == REGION_PWM) begin
                next_s.duty[ch] = wval[DUTY_W-1:0];
                next_s.pwmdir[ch] = wval[PWM_DIR_BIT];
                next_s.pdm[ch] = wval[PWM_PDM_BIT];
                next_s.shared_act[2*ch +: 2] = s.dout[SHARED_LSB + 2*ch +: 2]; // R25
            end else if (wb_adr_i == A_DOUT) begin
                next_s.dout = wval[N_OUT-1:0];
                next_s.ded_act = wval[N_DED_OUT-1:0]; // R25
            end else if (wb_adr_i == A_DINV) begin
                next_s.output_polarity_flip = wval[N_OUT-1:0];
            end else if (wb_adr_i == A_CTRL) begin
                next_s.wd_en = wval[CTRL_WDEN_BIT];
            end
        end
        // Any host access restarts the watchdog and restores the drive.
        if (req) begin // R01 R02
            next_s.wd_cnt = '0;
            next_s.tripped = 1'b0;
        end else if (!s.wd_en) begin
            next_s.wd_cnt = '0;
            next_s.tripped = 1'b0;
        end else if (s.wd_cnt == WDOG_W'(WDOG_LIMIT - 1)) begin
            next_s.tripped = 1'b1;
        end else if (!s.tripped) begin
            next_s.wd_cnt = s.wd_cnt + 1'b1;
        end
        // Pin values, the dedicated and shared pins each under its flip.
        next_s.pin_ded = s.ded_act ^ s.output_polarity_flip[N_DED_OUT-1:0]; // R14
        for (int i = 0; i < N_CH; i++) begin
            next_s.pin_first[i] = pwm_first[i] ^ s.shared_act[2*i]
                                  ^ s.output_polarity_flip[SHARED_LSB + 2*i]; // R16
            next_s.pin_second[i] = pwm_second[i] ^ s.shared_act[2*i + 1]
                                   ^ s.output_polarity_flip[SHARED_LSB + 2*i + 1]; // R04 R16
        end
        next_s.led = pwm_first[0] ^ pwm_second[0]; // R22
        next_s.oe = !s.tripped; // R01
    end

    // State register; pins start tristated.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s <= '0;
            s.wd_en <= 1'b1;
            s.tripped <= 1'b1;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // Outputs straight from the state register.
    assign wb_dat_o = s.rdata;
    assign wb_ack_o = s.ack;
    assign dedicated_output_bit_o = s.pin_ded;
    assign modulated_out_first_o = s.pin_first;
    assign modulated_out_second_o = s.pin_second;
    assign status_led_o = s.led;
    assign pin_oe_o = s.oe;
endmodule

// file: test/smio_top_properties.sv
// Checks on the servo motion I/O top ports.
module smio_top_props
    import smio_pkg::*;
#(
    parameter int WDOG_LIMIT = WDOG_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [N_DED_OUT-1:0] dedicated_output_bit_o,
    input wire logic pin_oe_o
);
    logic take;
    logic wden;
    int idle;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A request taken by the slave.
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;

    // Watchdog enable shadow and idle time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wden <= 1'b1;
            idle <= 0;
        end else if (take) begin
            idle <= 0;
            if (wb_we_i && wb_sel_i[0] && wb_adr_i[7:2] == A_CTRL[7:2]) begin
                wden <= wb_dat_i[CTRL_WDEN_BIT];
            end
        end else if (ce_i && idle < WDOG_LIMIT + 8) begin
            idle <= idle + 1;
        end
    end

    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    ack_answer_a: assert property (take |=> wb_ack_o)
        else $error("taken request got no ack");
    ack_cause_a: assert property (wb_ack_o |-> $past(take))
        else $error("ack without a taken request");
    oe_restore_a: assert property (take |-> ##[2:3] pin_oe_o)
        else $error("pins not driven after an access");
    oe_cause_a: assert property ($rose(pin_oe_o) |-> $past(wb_ack_o) || $past(wb_ack_o, 2))
        else $error("pins driven without an access");
    wdog_late_a: assert property (wden && idle >= WDOG_LIMIT + 4 |-> !pin_oe_o)
        else $error("watchdog did not release the pins");
    wdog_early_a: assert property ($fell(pin_oe_o) |-> idle >= WDOG_LIMIT - 2 && idle <= WDOG_LIMIT + 3)
        else $error("watchdog tripped at the wrong time");
    dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i)
        else $error("read data changed outside a read answer");
    ded_update_a: assert property (pin_oe_o && $past(pin_oe_o) && $changed(dedicated_output_bit_o)
        |-> $past(wb_ack_o) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
        else $error("dedicated outputs changed without a write");
endmodule

bind smio_top smio_top_props #(.WDOG_LIMIT(WDOG_LIMIT)) props_i (.*);

// file: test/smio_enc_model.sv
// Encoder model: four quadrature channels.
module smio_enc_model (
    input wire logic clk_i,
    input wire logic [3:0] fwd_i,
    input wire logic [3:0] rev_i,
    input wire logic [3:0] idx_i,
    input wire logic [3:0] glitch_i,
    output logic [3:0] phase_a_o,
    output logic [3:0] phase_b_o,
    output logic [3:0] index_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] st [4] = '{default: 2'h0};

    // One phase moves per step.
    always @(posedge clk_i) begin
        for (int i = 0; i < 4; i++) begin
            st[i] <= st[i] + 2'(fwd_i[i]) - 2'(rev_i[i]);
        end
    end

    // Gray order 00, 10, 11, 01 for forward travel; a glitch flips phase A briefly.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            phase_a_o[i] = (st[i] == 2'h1 || st[i] == 2'h2) ^ glitch_i[i];
            phase_b_o[i] = st[i][1];
        end
    end
    assign index_o = idx_i;
endmodule

// file: test/tb_smio_top.sv
// Self-checking bench for the servo motion I/O top.
module tb_smio_top
    import smio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, led, oe;
    logic [7:0] adr = 8'h00, din = 8'h00;
    logic [3:0] sel = 4'h0, fwd = 4'h0, rev = 4'h0, idx = 4'h0, glt = 4'h0, pa, pb, pz, pf, ps, pp;
    logic [31:0] wdat = 32'h0, dat_o;
    logic [9:0] dout;
    logic [17:0] outs = '0, flip = '0, cm = '0;
    int bad_count = 0, samples_checked = 0, seed = 75;
    int cnt [4] = '{0, 0, 0, 0};
    int hf [4] = '{default: 0}, hs [4] = '{default: 0}, tg [4] = '{default: 0};

    // Clock of 100 MHz.
    always #5 clk_i = ~clk_i;

    smio_top #(.WDOG_LIMIT(200)) smio_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .encoder_phase_a_in_i(pa), .encoder_phase_b_in_i(pb), .encoder_index_in_i(pz),
        .dedicated_input_bit_i(din), .dedicated_output_bit_o(dout), .modulated_out_first_o(pf),
        .modulated_out_second_o(ps), .status_led_o(led), .pin_oe_o(oe));
    smio_enc_model smio_enc_model_i (.clk_i(clk_i), .fwd_i(fwd), .rev_i(rev), .idx_i(idx), .glitch_i(glt),
        .phase_a_o(pa), .phase_b_o(pb), .index_o(pz));

    // Prints the verdict and stops the run.
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Compares a register or pin value.
    task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Compares a count within a tolerance.
    task automatic chk_near(input string nm, input int e, input int g, input int tol);
        samples_checked++;
        if (g < e - tol || g > e + tol) begin
            bad_count++;
            $display("unexpected %s expected %0d seen %0d", nm, e, g);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk_i);
        while (ack !== 1'b1) begin
            @(posedge clk_i);
            n++;
        end
        chk_reg("ack_delay", 32'h1, 32'(n));
        r = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    // Writes a modulator register.
    task automatic set_duty(input int c, input logic [13:0] v);
        logic [31:0] r;
        wb(1'b1, 8'(16 + 4 * c), 32'(v), r);
    endtask

    // Steps the encoders.
    task automatic step(input logic [3:0] f, input logic [3:0] b);
        fwd <= f;
        rev <= b;
        @(posedge clk_i);
        fwd <= 4'h0;
        rev <= 4'h0;
        repeat (40) @(posedge clk_i);
        for (int i = 0; i < 4; i++) begin
            cnt[i] += int'(f[i]) - int'(b[i]);
        end
    endtask

    // Reads a counter and compares count and arm flag.
    task automatic rd_cnt(input int c, input logic arm);
        logic [31:0] r;
        wb(1'b0, 8'(4 * c), 32'h0, r);
        chk_reg("count", {17'h0, arm, 14'(cnt[c])}, {17'h0, r[14:0]});
    endtask

    // Expected shared pin levels with the modulators idle.
    function automatic logic [3:0] sh(input int p);
        for (int c = 0; c < 4; c++) begin
            sh[c] = cm[SHARED_LSB + 2 * c + p] ^ flip[SHARED_LSB + 2 * c + p];
        end
    endfunction

    // Main sequence.
    initial begin
        logic [31:0] r, v;
        logic [15:0] tbl [8] = '{16'h8801, 16'h47ff, 16'hd801, 16'h57ff, 16'hf801, 16'h77ff, 16'h8800, 16'h0};
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk_reg("pin_oe", 32'h0, 32'(oe));
        wb(1'b0, A_CTRL, 32'h0, r);
        chk_reg("wdog_enable", 32'h1, 32'(r[CTRL_WDEN_BIT]));
        repeat (180) @(posedge clk_i);
        chk_reg("pin_oe", 32'h1, 32'(oe));
        repeat (30) @(posedge clk_i);
        chk_reg("pin_oe", 32'h0, 32'(oe));
        wb(1'b1, A_CTRL, 32'h0, r);
        repeat (250) @(posedge clk_i);
        chk_reg("pin_oe", 32'h1, 32'(oe));
        wb(1'b0, 8'h30, 32'h0, r);
        chk_reg("unmapped", 32'h0, r);
        for (int k = 0; k < 3; k++) begin
            flip = 18'($random(seed));
            outs = 18'($random(seed));
            wb(1'b1, A_DINV, 32'(flip), r);
            wb(1'b1, A_DOUT, 32'(outs), r);
            wb(1'b0, A_DOUT, 32'h0, r);
            chk_reg("out_reg", 32'(outs), 32'(r[17:0]));
            wb(1'b0, A_DINV, 32'h0, r);
            chk_reg("flip_reg", 32'(flip), 32'(r[17:0]));
            chk_reg("dedicated", 32'(outs[9:0] ^ flip[9:0]), 32'(dout));
            chk_reg("staged", {sh(1), sh(0)}, {ps, pf});
            for (int c = 0; c < 4; c++) begin
                set_duty(c, 14'h0);
            end
            cm = outs;
            repeat (3) @(posedge clk_i);
            chk_reg("shared", {sh(1), sh(0)}, {ps, pf});
        end
        flip = '0;
        cm = '0;
        wb(1'b1, A_DINV, 32'h0, r);
        wb(1'b1, A_DOUT, 32'h0, r);
        for (int k = 0; k < 30; k++) begin
            v = $random(seed);
            step(v[3:0] & ~v[7:4], v[7:4] & ~v[3:0]);
        end
        glt <= 4'hf;
        repeat (14) @(posedge clk_i);
        glt <= 4'h0;
        repeat (40) @(posedge clk_i);
        for (int c = 0; c < 4; c++) begin
            rd_cnt(c, 1'b0);
        end
        for (int k = 0; k < 4; k++) begin
            din <= 8'($random(seed));
            idx <= 4'($random(seed));
            repeat (20) @(posedge clk_i);
            wb(1'b0, A_DIN, 32'h0, r);
            chk_reg("inputs", {12'h0, pb, pa, pz, din}, r);
        end
        for (int c = 0; c < 4; c++) begin
            idx[c] <= 1'b1;
            repeat (40) @(posedge clk_i);
            wb(1'b1, 8'(4 * c), 32'h4000, r);
            rd_cnt(c, 1'b1);
            idx[c] <= 1'b0;
            repeat (40) @(posedge clk_i);
            rd_cnt(c, 1'b1);
            idx[c] <= 1'b1;
            repeat (40) @(posedge clk_i);
            cnt[c] = 0;
            rd_cnt(c, 1'b0);
        end
        foreach (tbl[k]) begin
            flip = 18'({4{tbl[k][13], 1'b0}}) << SHARED_LSB;
            wb(1'b1, A_DINV, 32'(flip), r);
            for (int c = 0; c < 4; c++) begin
                set_duty(c, tbl[k][13:0] & 14'h1fff);
            end
            repeat (30) @(posedge clk_i);
            chk_reg("pins", {{4{tbl[k][15] ^ tbl[k][13]}}, {4{tbl[k][14]}}}, {ps, pf});
            chk_reg("led", 32'(tbl[k][14] ^ tbl[k][15]), 32'(led));
        end
        wb(1'b1, A_DINV, 32'h0, r);
        set_duty(0, 14'h1e01);
        set_duty(1, 14'h03ff);
        set_duty(2, 14'h23ff);
        set_duty(3, 14'h0c01);
        pp = pf;
        repeat (20470) begin
            @(posedge clk_i);
            for (int c = 0; c < 4; c++) begin
                hf[c] += int'(pf[c]);
                hs[c] += int'(ps[c]);
                tg[c] += int'(pf[c] ^ pp[c]);
            end
            pp = pf;
        end
        chk_near("ch0_first", 5110, hf[0], 12);
        chk_near("ch0_second", 20470, hs[0], 0);
        chk_near("ch1_first", 10230, hf[1], 12);
        chk_near("ch1_edges", 8, tg[1], 1);
        chk_near("ch1_second", 0, hs[1], 0);
        chk_near("ch2_first", 10230, hf[2], 30);
        chk_near("ch2_edges", 6000, tg[2], 4000);
        chk_near("ch3_first", 0, hf[3], 0);
        chk_near("ch3_second", 10230, hs[3], 12);
        end_sim();
    end

    // Cuts a hang short.
    initial begin
        #1000000;
        chk_reg("timeout", 32'h0, 32'h1);
        end_sim();
    end
endmodule
